// ---- npbl_pkg.sv ----
// Behaviour
// - hold in reset while reset pin low
// - sleep only with 32 kHz clock present
// - snooze replaces sleep without clock
// - device picks sleep entry once permitted
// - sleep and snooze keep all context
// - shutdown exits only by full reset
// - link plain unless encryption enabled
// - temporary encryption lost at restart
// - permanent mode accepts only stored-key messages
// - session keys dropped at power cycle
// - per message encrypted or plain accepted
// - port select sampled at reset release
`default_nettype none
package npbl_pkg;
   // register offsets
   localparam logic [3:0] NPBL_REG_CTRL = 4'h0;
   localparam logic [3:0] NPBL_REG_BOOT = 4'h1;
   localparam logic [3:0] NPBL_REG_STAT = 4'h2;
   localparam logic [3:0] NPBL_REG_LINK = 4'h3;
   localparam logic [3:0] NPBL_REG_MSG = 4'h4;
   // ctrl bits
   localparam int NPBL_CTRL_PS = 0;
   localparam int NPBL_CTRL_SHUT = 1;
   localparam int NPBL_CTRL_IDLE = 2;
   // boot step codes written to boot register
   localparam logic [1:0] NPBL_STEP_CFG = 2'h0;
   localparam logic [1:0] NPBL_STEP_TRIG = 2'h1;
   localparam logic [1:0] NPBL_STEP_FW = 2'h2;
   localparam logic [1:0] NPBL_STEP_PLAT = 2'h3;
   // link bits
   localparam int NPBL_LINK_TEMP = 0;
   localparam int NPBL_LINK_PERM = 1;
   localparam int NPBL_LINK_KEY = 2;
   // message bits: bit0 encrypted, bit1 stored key used
   localparam int NPBL_MSG_ENC = 0;
   localparam int NPBL_MSG_STORED = 1;
   // low-power clock period 1/32 kHz in ns, detect window
   localparam int NPBL_LPCLK_NS = 31250;
   localparam int NPBL_CLK_NS = 100;
   localparam int NPBL_LP_TIMEOUT = 2 * NPBL_LPCLK_NS / NPBL_CLK_NS;
   typedef enum logic [2:0] {
      NPBL_RESET = 3'b000,
      NPBL_BOOTING = 3'b001,
      NPBL_ACTIVE = 3'b010,
      NPBL_SLEEP = 3'b011,
      NPBL_SNOOZE = 3'b100,
      NPBL_SHUTDOWN = 3'b101
   } npbl_state_t;
   typedef enum logic [1:0] {
      NPBL_PLAIN = 2'b00,
      NPBL_TEMP = 2'b01,
      NPBL_PERM = 2'b10
   } npbl_link_t;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } npbl_bus_t;
endpackage
`default_nettype wire

// ---- npbl_power_link_ctrl.sv ----
// The address map and the strobed register port were left to the implementer.
`default_nettype none
module npbl_power_link_ctrl
   import npbl_pkg::*;
#(
   parameter int LP_TIMEOUT = NPBL_LP_TIMEOUT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic chip_reset_low,
   input wire logic wake_request_pin,
   input wire logic low_power_clock_in,
   input wire logic host_port_select,
   input wire npbl_bus_t bus,
   input wire logic msgValid,
   input wire logic [1:0] msgKind,
   output logic [31:0] rdata,
   output logic msgAccept,
   output logic msgDrop,
   output logic sdioMode,
   output logic coreRunning,
   output npbl_state_t state
);
   // elaboration-time guard on the detect window
   // the window counter is 16 bits wide, so larger windows cannot be held
   // a window under two cycles would flag a live clock as lost
   if (LP_TIMEOUT < 2 || LP_TIMEOUT > 65535) begin : g_bad_timeout
      $error("LP_TIMEOUT out of range");
   end

   // pin front end
   // every pin comes from outside the clock domain
   // each passes two flops before any decision reads it
   // the cost is two cycles of latency on every pin event
   // reset pin, wake pin, slow clock and port select all share this
   // the synchronisers clear with rstn so the pin looks low after reset
   // a pin already high at rstn release then gives one clean release edge
   // two-flop synchronisers for pins
   logic [1:0] rstSync, wakeSync, lpSync, selSync;
   logic lpPrev;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync <= 2'h0;
         wakeSync <= 2'h0;
         lpSync <= 2'h0;
         selSync <= 2'h0;
         lpPrev <= 1'b0;
      end else begin
         rstSync <= {rstSync[0], chip_reset_low};
         wakeSync <= {wakeSync[0], wake_request_pin};
         lpSync <= {lpSync[0], low_power_clock_in};
         selSync <= {selSync[0], host_port_select};
         lpPrev <= lpSync[1];
      end
   end
   // synchronised reset pin level, high while the host lets us run
   logic pinHigh;
   assign pinHigh = rstSync[1];
   // synchronised wake request, high while the host wants us awake
   logic wakeReq;
   assign wakeReq = wakeSync[1];
   // release edge: synchronised reset pin rose
   logic pinHighD;
   logic releaseEdge;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinHighD <= 1'b0;
      end else begin
         pinHighD <= pinHigh;
      end
   end
   assign releaseEdge = pinHigh & ~pinHighD;

   // interface select latched at reset release
   // the select pin turns into a data line once the port is running
   // so its level is only trusted at the release edge itself
   // later wiggles on the pin must never move the chosen port
   // the two-cycle pin latency matches the reset pin path exactly,
   // so select and release are seen from the same pin instant
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdioMode <= 1'b0;
      end else if (releaseEdge) begin
         sdioMode <= selSync[1];
      end
   end

   // low-power clock presence detector; lost after two idle periods
   // the slow clock is treated as data and edge-detected on clk
   // any level change restarts the window and marks the clock present
   // a window that runs out without a change marks it absent
   // a stopped clock is only noticed after the full window has passed,
   // so sleep may be left a little late when the host pulls the clock
   // the counter saturates at the window end rather than wrapping
   logic [15:0] lpCount;
   logic lpPresent;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lpCount <= 16'h0000;
         lpPresent <= 1'b0;
      end else if (lpSync[1] != lpPrev) begin
         lpCount <= 16'h0000;
         lpPresent <= 1'b1;
      end else if (lpCount >= 16'(LP_TIMEOUT)) begin
         lpPresent <= 1'b0;
      end else begin
         lpCount <= lpCount + 16'h0001;
      end
   end

   // register decode
   // writes are single-cycle strobes, decoded combinationally
   // reads are decoded in the read-port process further down
   // status register has no write decode: it is read only
   logic wrCtrl, wrBoot, wrLink;
   assign wrCtrl = bus.wr && bus.addr == NPBL_REG_CTRL;
   assign wrBoot = bus.wr && bus.addr == NPBL_REG_BOOT;
   assign wrLink = bus.wr && bus.addr == NPBL_REG_LINK;

   // control bits; power-save permit, firmware idle hint
   // both clear while the reset pin is low, so a restart
   // never inherits a stale permit from the previous session
   // the shutdown bit is a pulse and is not stored here
   // idle stands in for the firmware's own view of radio activity
   logic psEnable, radioIdle;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         psEnable <= 1'b0;
         radioIdle <= 1'b0;
      end else if (!pinHigh) begin
         psEnable <= 1'b0;
         radioIdle <= 1'b0;
      end else if (wrCtrl) begin
         psEnable <= bus.wdata[NPBL_CTRL_PS];
         radioIdle <= bus.wdata[NPBL_CTRL_IDLE];
      end
   end

   // boot step tracker; out of order steps restart at config
   // steps only count while booting; other states ignore them
   // restarting at config on a wrong code keeps the order strict,
   // at the price of the host repeating every step after a slip
   // done is raised only by the platform step, the last one
   // reset and shutdown both wipe progress, so a full boot is needed
   logic [1:0] bootStep;
   logic bootDone;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bootStep <= NPBL_STEP_CFG;
         bootDone <= 1'b0;
      end else if (state == NPBL_RESET || state == NPBL_SHUTDOWN) begin
         bootStep <= NPBL_STEP_CFG;
         bootDone <= 1'b0;
      end else if (wrBoot && state == NPBL_BOOTING) begin
         if (bus.wdata[1:0] == bootStep) begin
            bootStep <= bootStep + 2'h1;
            bootDone <= (bootStep == NPBL_STEP_PLAT);
         end else begin
            bootStep <= NPBL_STEP_CFG;
         end
      end
   end

   // power state machine
   // reset leaves only towards booting, booting only towards active
   // active picks sleep or snooze by itself once power save is allowed
   // low-power states return to active and keep every setting
   // shutdown is a dead end left only through the reset pin
   // the reset pin override lives in the state register process
   // unknown codes fall back to reset through the default branch
   npbl_state_t next_state;
   always_comb begin
      next_state = state;
      case (state)
         NPBL_RESET: begin
            if (pinHigh) begin
               next_state = NPBL_BOOTING;
            end
         end
         NPBL_BOOTING: begin
            if (bootDone) begin
               next_state = NPBL_ACTIVE;
            end
         end
         NPBL_ACTIVE: begin
            // only host command enters shutdown
            if (wrCtrl && bus.wdata[NPBL_CTRL_SHUT]) begin
               next_state = NPBL_SHUTDOWN;
            end else if (psEnable && radioIdle && !wakeReq) begin
               // device decides entry itself
               next_state = lpPresent ? NPBL_SLEEP : NPBL_SNOOZE;
            end
         end
         NPBL_SLEEP: begin
            if (wakeReq || !psEnable || !lpPresent) begin
               next_state = NPBL_ACTIVE;
            end
         end
         NPBL_SNOOZE: begin
            if (wakeReq || !psEnable) begin
               next_state = NPBL_ACTIVE;
            end
         end
         NPBL_SHUTDOWN: begin
            next_state = NPBL_SHUTDOWN;
         end
         default: begin
            next_state = NPBL_RESET;
         end
      endcase
   end
   // any low reset pin forces reset state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= NPBL_RESET;
      end else if (!pinHigh) begin
         state <= NPBL_RESET;
      end else begin
         state <= next_state;
      end
   end

   // link mode and session key; context kept across sleep
   // link setup is only taken while active, never while booting
   // permanent wins over temporary when both bits are written
   // key flag only records that an exchange has completed;
   // the exchange itself lives outside this block
   // nothing here is cleared by sleep or snooze
   npbl_link_t linkMode;
   logic sessionKey;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         linkMode <= NPBL_PLAIN;
         sessionKey <= 1'b0;
      end else if (!pinHigh || state == NPBL_SHUTDOWN) begin
         // any restart: plain link, keys dropped
         linkMode <= NPBL_PLAIN;
         sessionKey <= 1'b0;
      end else if (wrLink && state == NPBL_ACTIVE) begin
         sessionKey <= bus.wdata[NPBL_LINK_KEY];
         if (bus.wdata[NPBL_LINK_PERM]) begin
            linkMode <= NPBL_PERM;
         end else if (bus.wdata[NPBL_LINK_TEMP]) begin
            linkMode <= NPBL_TEMP;
         end else begin
            linkMode <= NPBL_PLAIN;
         end
      end
   end

   // message acceptance filter
   // every message gets exactly one answer the cycle after it arrives
   // outside active every message is dropped, whatever its kind
   // the answer pair is registered so both outputs come from flops
   // accept and drop are always complements while a message stands
   // with no message both stay low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         msgAccept <= 1'b0;
         msgDrop <= 1'b0;
      end else if (!msgValid || state != NPBL_ACTIVE) begin
         msgAccept <= 1'b0;
         msgDrop <= msgValid;
      end else begin
         case (linkMode)
            NPBL_PERM: begin
               // only stored-key encrypted traffic
               msgAccept <= msgKind[NPBL_MSG_ENC] &&
                            msgKind[NPBL_MSG_STORED] && sessionKey;
               msgDrop <= !(msgKind[NPBL_MSG_ENC] &&
                            msgKind[NPBL_MSG_STORED] && sessionKey);
            end
            NPBL_TEMP: begin
               // either kind per message once key exists
               msgAccept <= !msgKind[NPBL_MSG_ENC] || sessionKey;
               msgDrop <= msgKind[NPBL_MSG_ENC] && !sessionKey;
            end
            default: begin
               // plain link carries only unencrypted traffic
               msgAccept <= !msgKind[NPBL_MSG_ENC];
               msgDrop <= msgKind[NPBL_MSG_ENC];
            end
         endcase
      end
   end

   // core clock gate level; off in low-power states
   // computed from the next state so the gate follows state exactly
   // the reset pin term keeps the core stopped during a pin reset
   // shutdown, sleep and snooze all stop the core clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         coreRunning <= 1'b0;
      end else begin
         coreRunning <= (next_state == NPBL_BOOTING ||
                         next_state == NPBL_ACTIVE) && pinHigh;
      end
   end

   // read port, data one cycle later; unmapped reads zero
   // data stands for exactly one cycle, zero otherwise,
   // so a late sample by the host reads zero, not stale data
   // the register bus never stalls the host
   // status packs clock presence, port mode, wake level and state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h00000000;
      end else if (bus.rd) begin
         case (bus.addr)
            NPBL_REG_CTRL: rdata <= {29'h0, radioIdle, 1'b0, psEnable};
            NPBL_REG_BOOT: rdata <= {29'h0, bootDone, bootStep};
            NPBL_REG_STAT: rdata <= {26'h0, lpPresent, sdioMode,
                                     wakeReq, state};
            NPBL_REG_LINK: rdata <= {28'h0, sessionKey, 1'b0, linkMode};
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ---- npbl_host_model.sv ----
`default_nettype none
module npbl_host_model (
   input wire logic clk,
   input wire logic lpOn,
   output logic low_power_clock_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div = 2'h0; // scaled down to fit the short detect window
   initial low_power_clock_in = 1'b0;
   // reference clock, stands still at 0 while the host stops it
   always @(posedge clk) begin
      div <= div + 2'h1;
      low_power_clock_in <= lpOn & div[1];
   end
endmodule
`default_nettype wire

// ---- npbl_plc_checker.sv ----
`default_nettype none
module npbl_plc_checker
   import npbl_pkg::*;
#(parameter int LP_TIMEOUT = 8) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic chip_reset_low,
   input wire npbl_bus_t bus,
   input wire logic msgValid,
   input wire logic [31:0] rdata,
   input wire logic msgAccept,
   input wire logic msgDrop,
   input wire logic sdioMode,
   input wire npbl_state_t state
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == '0)
      else $error("read data without read");
   chk_answer_cause: assert property ((msgAccept || msgDrop) |->
      $past(msgValid)) else $error("answer without message");
   chk_answer_once: assert property (msgValid |=> msgAccept ^ msgDrop)
      else $error("message not answered once");
   chk_drop_inactive: assert property (msgValid && state != NPBL_ACTIVE
      |=> msgDrop) else $error("message taken while not active");
   chk_pin_reset: assert property (!chip_reset_low [*4]
      |-> state == NPBL_RESET) else $error("pin low but not in reset");
   chk_shut_exit: assert property (state == NPBL_SHUTDOWN |=>
      state inside {NPBL_SHUTDOWN, NPBL_RESET}) else $error("left shutdown");
   chk_reset_exit: assert property (state == NPBL_RESET |=>
      state inside {NPBL_RESET, NPBL_BOOTING}) else $error("bad reset exit");
   chk_low_exit: assert property (state inside {NPBL_SLEEP, NPBL_SNOOZE}
      |=> state == $past(state) || state inside {NPBL_ACTIVE, NPBL_RESET})
      else $error("bad low power exit");
   chk_port_hold: assert property (state inside {NPBL_ACTIVE, NPBL_SLEEP,
      NPBL_SNOOZE} |-> $stable(sdioMode)) else $error("port mode moved");
   cov_sleep: cover property (state == NPBL_SLEEP);
   cov_snooze: cover property (state == NPBL_SNOOZE);
   cov_shut: cover property (state == NPBL_SHUTDOWN);
   cov_accept: cover property (msgAccept);
endmodule
bind npbl_power_link_ctrl npbl_plc_checker #(.LP_TIMEOUT(LP_TIMEOUT)) u_chk (
   .clk(clk), .rstn(rstn), .chip_reset_low(chip_reset_low), .bus(bus),
   .msgValid(msgValid), .rdata(rdata), .msgAccept(msgAccept),
   .msgDrop(msgDrop), .sdioMode(sdioMode), .state(state));
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb;
   import npbl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, resetPin = 1'b0, wake = 1'b0;
   logic portSel = 1'b1, lpOn = 1'b0, lpClk, msgValid = 1'b0;
   logic [1:0] msgKind = 2'h0;
   npbl_bus_t bus = '0;
   logic [31:0] rdata;
   logic msgAccept, msgDrop, sdioMode, coreRunning;
   npbl_state_t state;
   int errors = 0, cmp_count = 0;
   // link setting, message kind, expected accept
   logic [5:0] rows [9] = '{6'h01, 6'h02, 6'h09, 6'h0A, 6'h29, 6'h2B,
      6'h37, 6'h32, 6'h30};
   always #50 clk = ~clk;
   npbl_host_model host (.clk(clk), .lpOn(lpOn), .low_power_clock_in(lpClk));
   npbl_power_link_ctrl #(.LP_TIMEOUT(8)) dut (.clk(clk), .rstn(rstn),
      .chip_reset_low(resetPin), .wake_request_pin(wake),
      .low_power_clock_in(lpClk), .host_port_select(portSel), .bus(bus),
      .msgValid(msgValid), .msgKind(msgKind), .rdata(rdata),
      .msgAccept(msgAccept), .msgDrop(msgDrop), .sdioMode(sdioMode),
      .coreRunning(coreRunning), .state(state));
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(logic ok, string what);
      cmp_count++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   // one-cycle strobes, released on the edge that takes them
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] exp, string what);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus <= '0;
      #1 check(rdata === exp, what);
   endtask
   task automatic msg(logic [1:0] k, logic acc, string what);
      @(posedge clk);
      msgValid <= 1'b1;
      msgKind <= k;
      @(posedge clk);
      msgValid <= 1'b0;
      #1 check(msgAccept === acc && msgDrop === !acc, what);
   endtask
   task automatic waitState(npbl_state_t s);
      for (int i = 0; i < 300 && state !== s; i++) begin
         @(posedge clk);
         #1;
      end
      check(state === s, "state not reached");
      if (state !== s) print_verdict();
   endtask
   // step codes packed two bits each, first step lowest
   task automatic boot(logic [7:0] codes, int n);
      for (int i = 0; i < n; i++) wr(NPBL_REG_BOOT, {30'h0, codes[2*i+:2]});
   endtask
   task automatic pinReset();
      @(posedge clk);
      resetPin <= 1'b0;
      repeat (6) @(posedge clk);
      #1 check(state === NPBL_RESET, "not held in reset");
      @(posedge clk);
      resetPin <= 1'b1;
      waitState(NPBL_BOOTING);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check(state === NPBL_RESET && rdata === '0, "reset values");
      pinReset();
      check(sdioMode === 1'b1, "sd port not chosen");
      portSel <= 1'b0;
      $display("reset test done");
      wr(NPBL_REG_LINK, 32'h5);
      boot(8'h38, 3);
      rd(NPBL_REG_STAT, {27'h0, 2'b10, NPBL_BOOTING}, "bad order");
      boot(8'hE4, 4);
      waitState(NPBL_ACTIVE);
      check(coreRunning === 1'b1, "core stopped while active");
      rd(NPBL_REG_LINK, 32'h0, "link write while booting");
      rd(4'hF, 32'h0, "unmapped read");
      $display("boot test done");
      foreach (rows[i]) begin
         wr(NPBL_REG_LINK, {29'h0, rows[i][5:3]});
         msg(rows[i][2:1], rows[i][0], "row message");
      end
      $display("message table done");
      lpOn <= 1'b1;
      wr(NPBL_REG_CTRL, 32'h4);
      repeat (20) @(posedge clk);
      #1 check(state === NPBL_ACTIVE, "slept without permit");
      wr(NPBL_REG_CTRL, 32'h5);
      waitState(NPBL_SLEEP);
      @(posedge clk);
      #1 check(coreRunning === 1'b0, "core running in sleep");
      wake <= 1'b1;
      waitState(NPBL_ACTIVE);
      msg(2'h3, 1'b1, "context lost");
      lpOn <= 1'b0;
      repeat (20) @(posedge clk);
      wake <= 1'b0;
      waitState(NPBL_SNOOZE);
      wr(NPBL_REG_CTRL, 32'h0);
      waitState(NPBL_ACTIVE);
      $display("power test done");
      wr(NPBL_REG_CTRL, 32'h2);
      waitState(NPBL_SHUTDOWN);
      wake <= 1'b1;
      repeat (20) @(posedge clk);
      #1 check(state === NPBL_SHUTDOWN, "woke from shutdown");
      check(coreRunning === 1'b0, "core running in shutdown");
      msg(2'h0, 1'b0, "message in shutdown");
      wake <= 1'b0;
      pinReset();
      check(sdioMode === 1'b0, "serial port not chosen");
      rd(NPBL_REG_LINK, 32'h0, "link kept over reset");
      boot(8'hE4, 4);
      waitState(NPBL_ACTIVE);
      msg(2'h1, 1'b0, "encrypted after restart");
      msg(2'h0, 1'b1, "plain after restart");
      $display("shutdown test done");
      print_verdict();
   end
endmodule
`default_nettype wire
